// *** idp_port.sv ***
// sixteen-in, sixteen-out isolated digital port with edge interrupts
// assumes synchronous pins, an axi4-lite master and a base from configuration
`timescale 1ns/1ps
module idp_port
(
	// clock, reset, enable
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	// window base
	input wire logic [31:5] i_io_base,
	// axi4-lite write
	input wire logic [31:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// input pins, high level is data 0
	input wire logic [15:0] i_din_pin,
	// open-collector output pins
	input wire logic [15:0] i_dout_pin,
	output logic [15:0] o_dout_pin,
	output logic [15:0] o_dout_oe,
	// interrupt
	output logic o_irq
);
	// register file and the write being assembled
	idp_pkg::idp_regs_t regs;
	idp_pkg::idp_regs_t next_regs;
	idp_pkg::idp_wr_t wr;
	idp_pkg::idp_wr_t next_wr;

	// write response
	logic bvalid;
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;

	// read response
	logic rvalid;
	logic next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;

	// interrupt request
	logic irq;
	logic next_irq;

	// input path
	logic [15:0] filt;
	logic [15:0] prev_filt;
	logic [15:0] next_prev_filt;
	logic [15:0] toward_high;
	logic [15:0] toward_low;
	logic [15:0] events;
	logic [15:0] in_data;

	// bus decode
	logic [15:0] wmask;
	logic [15:0] wval;
	logic commit;
	logic wr_hit;
	logic rd_hit;
	logic aw_take;
	logic w_take;
	logic ar_take;

	// input filtering, one filter per channel
	// each channel keeps its own counter, so chatter on one never delays another
	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_filt
			idp_filter u_filt
			(
				.i_clk_sys(i_clk_sys),
				.i_reset(i_reset),
				.i_clk_en(i_clk_en),
				.i_raw(i_din_pin[g]),
				.o_level(filt[g])
			);
		end
	endgenerate

	assign in_data = ~filt;

	// edge detection on the filtered pin level
	// prev_filt resets to the filter's reset level, so no false edge follows reset
	assign toward_high = ~prev_filt & filt;
	assign toward_low = prev_filt & ~filt;
	assign events = (regs.edge_sel & toward_high) | (~regs.edge_sel & toward_low);

	// bus handshakes; ready is withheld while the clock enable is low
	assign o_s_axi_awready = i_clk_en & ~wr.aw_held & ~bvalid;
	assign o_s_axi_wready = i_clk_en & ~wr.w_held & ~bvalid;
	assign o_s_axi_arready = i_clk_en & ~rvalid;
	assign aw_take = i_s_axi_awvalid & o_s_axi_awready;
	assign w_take = i_s_axi_wvalid & o_s_axi_wready;
	assign ar_take = i_s_axi_arvalid & o_s_axi_arready;

	// a write is applied at the edge after both halves are held
	assign commit = wr.aw_held & wr.w_held;

	// the window is matched on the upper address bits only
	assign wr_hit = (wr.addr[31:5] == i_io_base);
	assign rd_hit = (i_s_axi_araddr[31:5] == i_io_base);

	// byte lanes 0 and 1 carry the sixteen register bits
	assign wmask = {{8{wr.strb[1]}}, {8{wr.strb[0]}}};
	assign wval = wr.data[15:0];

	// write channel capture
	// address and data may come in either order; the response follows both
	always_comb
	begin
		next_wr = wr;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (aw_take)
		begin
			next_wr.aw_held = 1'h1;
			next_wr.addr = i_s_axi_awaddr;
		end
		if (w_take)
		begin
			next_wr.w_held = 1'h1;
			next_wr.data = i_s_axi_wdata;
			next_wr.strb = i_s_axi_wstrb;
		end
		if (commit)
		begin
			next_wr.aw_held = 1'h0;
			next_wr.w_held = 1'h0;
			next_bvalid = 1'h1;
			next_bresp = wr_hit ? idp_pkg::RESP_OKAY : idp_pkg::RESP_DECERR;
		end
		else if (bvalid && i_s_axi_bready)
			next_bvalid = 1'h0;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			wr <= '0;
			bvalid <= 1'h0;
			bresp <= idp_pkg::RESP_OKAY;
		end
		else if (i_clk_en)
		begin
			wr <= next_wr;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
		end
	end

	// register updates from writes and input events
	always_comb
	begin
		next_regs = regs;
		next_prev_filt = filt;
		// outside the window, and at read-only offsets, a write changes nothing
		if (commit && wr_hit)
		begin
			unique case (wr.addr[4:0])
				idp_pkg::OFS_OUT:
					next_regs.out_data = (regs.out_data & ~wmask) | (wval & wmask);
				idp_pkg::OFS_EDGE:
					next_regs.edge_sel = (regs.edge_sel & ~wmask) | (wval & wmask);
				idp_pkg::OFS_STAT:
					next_regs.status = regs.status & ~(wval & wmask);
				idp_pkg::OFS_MASK:
					next_regs.mask = (regs.mask & ~wmask) | (wval & wmask);
				default:
					next_regs = regs;
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_regs.status = next_regs.status | events;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			regs.out_data <= idp_pkg::RST_OUT;
			regs.edge_sel <= idp_pkg::RST_EDGE;
			regs.status <= idp_pkg::RST_STAT;
			regs.mask <= idp_pkg::RST_MASK;
			prev_filt <= {16{idp_pkg::RST_FILT}};
		end
		else if (i_clk_en)
		begin
			regs <= next_regs;
			prev_filt <= next_prev_filt;
		end
	end

	// read channel
	// the word is captured at the take edge; a later pin change needs a new read
	always_comb
	begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (ar_take)
		begin
			next_rvalid = 1'h1;
			next_rdata = 32'h0000_0000;
			next_rresp = idp_pkg::RESP_OKAY;
			if (!rd_hit)
				next_rresp = idp_pkg::RESP_DECERR;
			else
			begin
				unique case (i_s_axi_araddr[4:0])
					idp_pkg::OFS_IN:
						next_rdata = {16'h0000, in_data};
					idp_pkg::OFS_OUT:
						next_rdata = {16'h0000, regs.out_data};
					idp_pkg::OFS_EDGE:
						next_rdata = {16'h0000, regs.edge_sel};
					idp_pkg::OFS_STAT:
						next_rdata = {16'h0000, regs.status};
					idp_pkg::OFS_MASK:
						next_rdata = {16'h0000, regs.mask};
					idp_pkg::OFS_PINBACK:
						next_rdata = {16'h0000, ~i_dout_pin};
					default:
						next_rdata = 32'h0000_0000;
				endcase
			end
		end
		else if (rvalid && i_s_axi_rready)
			next_rvalid = 1'h0;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			rvalid <= 1'h0;
			rdata <= 32'h0000_0000;
			rresp <= idp_pkg::RESP_OKAY;
		end
		else if (i_clk_en)
		begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// interrupt level, registered so the request line never glitches
	always_comb
	begin
		next_irq = |(regs.status & regs.mask);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			irq <= 1'h0;
		else if (i_clk_en)
			irq <= next_irq;
	end

	// outputs
	assign o_s_axi_bvalid = bvalid;
	assign o_s_axi_bresp = bresp;
	assign o_s_axi_rvalid = rvalid;
	assign o_s_axi_rdata = rdata;
	assign o_s_axi_rresp = rresp;

	// a data 1 pulls the pin low; a data 0 releases it
	assign o_dout_pin = 16'h0000;
	assign o_dout_oe = regs.out_data;
	assign o_irq = irq;
endmodule // idp_port

// *** idp_pkg.sv ***
// constants and types of the isolated digital i/o interrupt port
// assumes a 25 mhz system clock and an axi4-lite register bus
package idp_pkg;

	// clock and timing
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned RESPONSE_MAX_NS = 200000;
	localparam int unsigned FILTER_TIME_NS = 10000;
	localparam int unsigned FILTER_CYC = (FILTER_TIME_NS * CLK_MHZ) / 1000;
	localparam int unsigned FILTER_CW = 8;
	localparam logic [FILTER_CW-1:0] FILTER_COUNT = FILTER_CW'(FILTER_CYC);

	// sizes
	localparam int unsigned CH = 16;
	localparam int unsigned WIN_BITS = 5;

	// register offsets inside the 32-byte window
	localparam logic [WIN_BITS-1:0] OFS_IN = 5'h00;
	localparam logic [WIN_BITS-1:0] OFS_OUT = 5'h04;
	localparam logic [WIN_BITS-1:0] OFS_EDGE = 5'h08;
	localparam logic [WIN_BITS-1:0] OFS_STAT = 5'h0c;
	localparam logic [WIN_BITS-1:0] OFS_MASK = 5'h10;
	localparam logic [WIN_BITS-1:0] OFS_PINBACK = 5'h14;

	// reset values
	localparam logic [CH-1:0] RST_OUT = 16'h0000;
	localparam logic [CH-1:0] RST_EDGE = 16'h0000;
	localparam logic [CH-1:0] RST_STAT = 16'h0000;
	localparam logic [CH-1:0] RST_MASK = 16'h0000;
	localparam logic RST_FILT = 1'h1;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [CH-1:0] out_data;
		logic [CH-1:0] edge_sel;
		logic [CH-1:0] status;
		logic [CH-1:0] mask;
	} idp_regs_t;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} idp_wr_t;

endpackage

// *** idp_filter.sv ***
// one input channel filter: passes a pin level only after it held still
// assumes the pin is already synchronous to i_clk_sys
`timescale 1ns/1ps
module idp_filter
(
	// clock, reset, enable
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_clk_en,
	// raw and filtered pin level
	input wire logic i_raw,
	output logic o_level
);
	logic level;
	logic next_level;
	logic [idp_pkg::FILTER_CW-1:0] cnt;
	logic [idp_pkg::FILTER_CW-1:0] next_cnt;

	always_comb
	begin
		next_level = level;
		next_cnt = '0;
		if (i_raw != level)
		begin
			// pulses shorter than the filter time never reach the output
			if (cnt == idp_pkg::FILTER_COUNT - 8'h01)
				next_level = i_raw;
			else
				next_cnt = cnt + 8'h01;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			level <= idp_pkg::RST_FILT;
			cnt <= '0;
		end
		else if (i_clk_en)
		begin
			level <= next_level;
			cnt <= next_cnt;
		end
	end

	assign o_level = level;
endmodule // idp_filter

// *** idp_pin_load.sv ***
// open-collector pin load: a pull-up on every output line
// assumes the port only ever drives low while its enable is high
`timescale 1ns/1ps
module idp_pin_load
(
	// port side
	input wire logic [15:0] i_oe,
	input wire logic [15:0] i_drv,
	// sensed pin level
	output logic [15:0] o_level
);
	assign o_level = (i_oe & i_drv) | ~i_oe;
endmodule // idp_pin_load

// *** idp_port_properties.sv ***
// bus and output checks on the ports of idp_port
// assumes one clock domain with a synchronous reset
`timescale 1ns/1ps
module idp_port_properties
(
	// watched ports
	input wire logic i_clk_sys, i_reset, i_clk_en,
	input wire logic [31:5] i_io_base,
	input wire logic [31:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid, o_s_axi_arready,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid, o_s_axi_bvalid,
	input wire logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
	input wire logic [15:0] o_dout_pin, o_dout_oe,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_ar; i_s_axi_arvalid && o_s_axi_arready; endsequence
	sequence s_in; s_ar ##0 (i_s_axi_araddr[31:5] == i_io_base); endsequence
	sequence s_out; s_ar ##0 (i_s_axi_araddr[31:5] != i_io_base); endsequence
	sequence s_wr; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	endsequence
	a_out_off: assert property ($past(i_reset) |-> o_dout_oe == 16'h0000 && !o_irq)
		else $error("output on after reset");
	a_oc_low: assert property (o_dout_pin == 16'h0000)
		else $error("pin driven high");
	a_rd_ans: assert property (s_ar |=> o_s_axi_rvalid)
		else $error("no read answer");
	a_rd_decerr: assert property (s_out |=> o_s_axi_rresp == idp_pkg::RESP_DECERR)
		else $error("outside read not refused");
	a_rd_okay: assert property (s_in |=> o_s_axi_rresp == idp_pkg::RESP_OKAY)
		else $error("window read refused");
	a_wr_ans: assert property (s_wr |=> !o_s_axi_awready ##1 o_s_axi_bvalid)
		else $error("no write answer");
	a_b_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while busy");
	a_en_off: assert property (!i_clk_en |-> !(o_s_axi_arready || o_s_axi_awready))
		else $error("ready while disabled");
endmodule // idp_port_properties
bind idp_port idp_port_properties u_props (.*);

// *** isolated_dio_interrupt_port_tb.sv ***
// self-checking bench of idp_port with an open-collector pin load
// assumes the register map and filter time of idp_pkg
`timescale 1ns/1ps
module isolated_dio_interrupt_port_tb;
	localparam logic [31:0] BASE = 32'h00000300;
	logic i_clk_sys = 1'h0, i_reset = 1'h1, i_clk_en = 1'h1, i_s_axi_awvalid = 1'h0;
	logic i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0;
	logic i_s_axi_rready = 1'h0, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic o_s_axi_arready, o_s_axi_rvalid, o_irq;
	logic [31:0] i_s_axi_awaddr = 32'h0, i_s_axi_wdata = 32'h0, i_s_axi_araddr = 32'h0;
	logic [31:0] o_s_axi_rdata;
	logic [31:5] i_io_base = BASE[31:5];
	logic [3:0] i_s_axi_wstrb = 4'hf;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic [15:0] i_din_pin = 16'hffff, i_dout_pin, o_dout_pin, o_dout_oe;
	int failures = 0;
	int n_tests = 0;
	idp_port u_dut (.*);
	idp_pin_load u_load (.i_oe(o_dout_oe), .i_drv(o_dout_pin), .o_level(i_dout_pin));
	initial
		forever #20 i_clk_sys = ~i_clk_sys;
	task automatic chk(input string s, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
		logic ta, tw, tb;
		@(posedge i_clk_sys);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		do
		begin
			@(negedge i_clk_sys);
			ta = i_s_axi_awvalid && o_s_axi_awready;
			tw = i_s_axi_wvalid && o_s_axi_wready;
			tb = o_s_axi_bvalid;
			if (tb)
				chk("bresp", 32'(r), 32'(o_s_axi_bresp));
			@(posedge i_clk_sys);
			if (ta)
				i_s_axi_awvalid <= 1'h0;
			if (tw)
				i_s_axi_wvalid <= 1'h0;
		end
		while (!tb);
		i_s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a, e, input logic [1:0] r);
		logic ta, tr;
		@(posedge i_clk_sys);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		do
		begin
			@(negedge i_clk_sys);
			ta = i_s_axi_arvalid && o_s_axi_arready;
			tr = o_s_axi_rvalid;
			if (tr)
			begin
				chk("rdata", e, o_s_axi_rdata);
				chk("rresp", 32'(r), 32'(o_s_axi_rresp));
			end
			@(posedge i_clk_sys);
			if (ta)
				i_s_axi_arvalid <= 1'h0;
		end
		while (!tr);
		i_s_axi_rready <= 1'h0;
	endtask
	task automatic pins(input logic [15:0] v, input int n);
		@(posedge i_clk_sys);
		i_din_pin <= v;
		repeat (n) @(posedge i_clk_sys);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_out();
		wr(BASE + 32'h4, 32'h8001, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("oe", 32'h8001, 32'(o_dout_oe));
		rd(BASE + 32'h14, 32'h8001, idp_pkg::RESP_OKAY);
		wr(BASE + 32'h24, 32'hffff, idp_pkg::RESP_DECERR);
		rd(BASE + 32'h4, 32'h8001, idp_pkg::RESP_OKAY);
		rd(BASE + 32'h18, 32'h0, idp_pkg::RESP_OKAY);
		rd(BASE - 32'h20, 32'h0, idp_pkg::RESP_DECERR);
		i_s_axi_wstrb <= 4'h1;
		wr(BASE + 32'h4, 32'h7ffe, idp_pkg::RESP_OKAY);
		i_s_axi_wstrb <= 4'hf;
		rd(BASE + 32'h4, 32'h80fe, idp_pkg::RESP_OKAY);
		rd(BASE + 32'h14, 32'h80fe, idp_pkg::RESP_OKAY);
		$display("t_out done");
	endtask
	task automatic t_irq();
		pins(16'hfffe, 100);
		pins(16'hffff, 300);
		rd(BASE + 32'hc, 32'h0, idp_pkg::RESP_OKAY);
		pins(16'hfffe, 300);
		rd(BASE, 32'h1, idp_pkg::RESP_OKAY);
		rd(BASE + 32'hc, 32'h1, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("irq masked", 32'h0, 32'(o_irq));
		wr(BASE + 32'h10, 32'h1, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("irq", 32'h1, 32'(o_irq));
		wr(BASE + 32'hc, 32'h1, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("irq cleared", 32'h0, 32'(o_irq));
		wr(BASE + 32'h8, 32'hffff, idp_pkg::RESP_OKAY);
		pins(16'hffff, 300);
		rd(BASE + 32'hc, 32'h1, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("irq rise", 32'h1, 32'(o_irq));
		wr(BASE + 32'hc, 32'h1, idp_pkg::RESP_OKAY);
		pins(16'hfffe, 300);
		rd(BASE + 32'hc, 32'h0, idp_pkg::RESP_OKAY);
		$display("t_irq done");
	endtask
	task automatic t_reset();
		rd(BASE, 32'h0, idp_pkg::RESP_OKAY);
		rd(BASE + 32'h4, 32'h0, idp_pkg::RESP_OKAY);
		@(negedge i_clk_sys);
		chk("oe reset", 32'h0, 32'(o_dout_oe));
		chk("irq reset", 32'h0, 32'(o_irq));
		$display("t_reset done");
	endtask
	task automatic t_en();
		@(posedge i_clk_sys);
		i_clk_en <= 1'h0;
		pins(16'hffff, 300);
		@(negedge i_clk_sys);
		chk("arready off", 32'h0, 32'(o_s_axi_arready));
		chk("awready off", 32'h0, 32'(o_s_axi_awready));
		@(posedge i_clk_sys);
		i_clk_en <= 1'h1;
		rd(BASE, 32'h1, idp_pkg::RESP_OKAY);
		$display("t_en done");
	endtask
	task automatic t_rerun();
		@(posedge i_clk_sys);
		i_reset <= 1'h1;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'h0;
		t_reset();
		$display("t_rerun done");
	endtask
	initial
	begin
		#400000;
		failures++;
		wrap_up();
	end
	initial
	begin
		repeat (8) @(posedge i_clk_sys);
		i_reset <= 1'h0;
		t_reset();
		t_out();
		t_irq();
		t_en();
		t_rerun();
		wrap_up();
	end
endmodule // isolated_dio_interrupt_port_tb
